// [hw/ulf_pkg.sv]
// Behaviour
// - Length code 00,01,10,11 gives 5,6,7,8 data bits both ways.
// - Stop select 0: one stop; 1: 1.5 for five bits, else two.
// - Parity code xx0 none, 001 odd, 011 even; made on send, checked on receive.
// - Code 101 forces parity one, 111 forces zero; receive checks forced value.
// - Nine-bit mode disables parity and ignores the parity field.
// - Break bit set holds serial output low outside loopback; clear resumes normal sending.
// - Divisor access enable steers offsets 0 and 1 to divisor bytes.
// - Line status visible only with divisor access and hide bit both 0.
// - Status bit 0 shows receive buffer holds a character.
// - Status bit 1 sets when a character arrives into a full buffer.
// - Status bit 2 flags bad parity, or the ninth bit in nine-bit mode.
// - Status bit 3 flags a non-break character whose stop bit sampled low.
// - Status bit 5 shows transmit holding buffer empty.
// - Status bit 6 shows holding buffer empty and shifter idle.
// - Status bit 7 shows a held error; a status read clears it.
// - Break is input low through start, data, parity and first stop.
// - Break pushes one zero character with break flag, then waits high.
// - Status bit 4 sets with break character at head; status read clears.
// - Modem bits 0 and 1 drive active-low terminal ready and request.
// - Modem bit 4 selects loopback; bits 2, 3, 6, 7 do nothing.
// - Modem bit 5 enables automatic clear/request flow control in FIFO mode.
// - Receiver status interrupt follows error bits 1 to 4, masked by enable.
package ulf_pkg;
	// ****************************************************************
	// Register indices, byte address is four times the index
	// ****************************************************************
	localparam int AXI_ADDR_W = 6;
	localparam logic [3:0] IDX_DATA = 4'h0;
	localparam logic [3:0] IDX_IRQ_EN = 4'h1;
	localparam logic [3:0] IDX_FIFO = 4'h2;
	localparam logic [3:0] IDX_LINE_FMT = 4'h3;
	localparam logic [3:0] IDX_MODEM = 4'h4;
	localparam logic [3:0] IDX_LINE_STAT = 4'h5;
	localparam logic [3:0] IDX_ADD_CTL = 4'h8;
	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int FMT_PAR_EN = 3;
	localparam int FMT_PAR_EVEN = 4;
	localparam int FMT_PAR_FORCE = 5;
	localparam int FMT_BREAK = 6;
	localparam int FMT_DIV_ACCESS = 7;
	localparam int FMT_STOP = 2;
	localparam int MDM_DTR = 0;
	localparam int MDM_RTS = 1;
	localparam int MDM_LOOP = 4;
	localparam int MDM_AUTO_FLOW = 5;
	localparam int ADD_NINE = 0;
	localparam int ADD_TX_NINTH = 1;
	localparam int ADD_HIDE_STAT = 6;
	localparam int IRQ_RX_STAT = 2;
	// ****************************************************************
	// Reset values and timing
	// ****************************************************************
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [15:0] DIV_RST = 16'h0001;
	localparam logic [5:0] TICKS_BIT = 6'h10;
	localparam logic [5:0] TICKS_STOP15 = 6'h18;
	localparam logic [5:0] TICKS_STOP2 = 6'h20;
	localparam logic [3:0] TICKS_HALF = 4'h7;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [4:0] {
		TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
		TX_PAR = 5'b01000, TX_STOP = 5'b10000
	} ulf_tx_e;
	typedef enum logic [5:0] {
		RX_IDLE = 6'b000001, RX_START = 6'b000010, RX_DATA = 6'b000100,
		RX_PAR = 6'b001000, RX_STOP = 6'b010000, RX_BRKW = 6'b100000
	} ulf_rx_e;
endpackage

// [hw/ulf_ser_if.sv]
`timescale 1ns/1ns
// ****************************************************************
// Link between register side and serial engine
// ****************************************************************
interface ulf_ser_if;
	logic [15:0] divisor;
	logic [1:0] word_len;
	logic two_stop, par_en, par_even, par_force, nine_bit, tx_ninth, cts_ok;
	logic tx_valid, tx_take, tx_idle, tx_line, rx_line;
	logic [7:0] tx_data, rx_data;
	logic rx_push, rx_perr, rx_ferr, rx_brk;
	modport core (output divisor, word_len, two_stop, par_en, par_even, par_force,
		nine_bit, tx_ninth, cts_ok, tx_valid, tx_data, rx_line,
		input tx_take, tx_idle, tx_line, rx_data, rx_push, rx_perr, rx_ferr, rx_brk);
	modport eng (input divisor, word_len, two_stop, par_en, par_even, par_force,
		nine_bit, tx_ninth, cts_ok, tx_valid, tx_data, rx_line,
		output tx_take, tx_idle, tx_line, rx_data, rx_push, rx_perr, rx_ferr, rx_brk);
endinterface

// [hw/ulf_serial.sv]
`timescale 1ns/1ns
// ****************************************************************
// Serial engine: baud tick, transmitter and receiver
// ****************************************************************
module ulf_serial (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	ulf_ser_if.eng s // Format in, characters both ways
);
	logic [15:0] bcnt;
	logic tick;
	ulf_pkg::ulf_tx_e tst;
	ulf_pkg::ulf_rx_e rst;
	logic [5:0] tcnt;
	logic [3:0] tbit, rbit, rcnt, nbits;
	logic [8:0] tsh, rsh;
	logic tpar, rpar, rzero;
	logic [5:0] stop_len;
	logic [7:0] mask;

	// Character geometry from the format fields
	always_comb begin
		mask = 8'hff >> (2'd3 - s.word_len);
		nbits = s.nine_bit ? 4'd9 : 4'd5 + {2'b00, s.word_len};
		stop_len = !s.two_stop ? ulf_pkg::TICKS_BIT :
			(s.word_len == 2'b00 ? ulf_pkg::TICKS_STOP15 : ulf_pkg::TICKS_STOP2);
	end

	// Parity of a masked character, forced or computed
	function automatic logic par_of(input logic [7:0] d, input logic ev, input logic fo);
		par_of = fo ? !ev : (ev ? ^d : !(^d));
	endfunction

	assign s.tx_idle = (tst == ulf_pkg::TX_IDLE);

	// Sixteen ticks per bit from the divisor
	always_ff @(posedge aclk) begin
		if (!aresetn || bcnt == 16'h0000) begin
			bcnt <= (!aresetn || s.divisor == 16'h0000) ? 16'h0000 : s.divisor - 16'h0001;
			tick <= aresetn;
		end else begin
			bcnt <= bcnt - 16'h0001;
			tick <= 1'b0;
		end
	end

	// Transmitter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tst <= ulf_pkg::TX_IDLE;
			s.tx_line <= 1'b1;
			s.tx_take <= 1'b0;
			tcnt <= 6'h00;
			tbit <= 4'h0;
			tsh <= 9'h000;
			tpar <= 1'b0;
		end else begin
			s.tx_take <= 1'b0;
			if (tick) begin
				tcnt <= tcnt + 6'h01;
				case (tst)
					ulf_pkg::TX_IDLE: begin
						tcnt <= 6'h00;
						if (s.tx_valid && s.cts_ok) begin
							s.tx_take <= 1'b1;
							tsh <= {s.tx_ninth, s.tx_data & mask};
							tpar <= par_of(s.tx_data & mask, s.par_even, s.par_force);
							s.tx_line <= 1'b0;
							tst <= ulf_pkg::TX_START;
						end
					end
					ulf_pkg::TX_START: if (tcnt == ulf_pkg::TICKS_BIT - 6'h01) begin
						tcnt <= 6'h00;
						tbit <= 4'h0;
						s.tx_line <= tsh[0];
						tst <= ulf_pkg::TX_DATA;
					end
					ulf_pkg::TX_DATA: if (tcnt == ulf_pkg::TICKS_BIT - 6'h01) begin
						tcnt <= 6'h00;
						if (tbit == nbits - 4'h1) begin
							s.tx_line <= s.par_en ? tpar : 1'b1;
							tst <= s.par_en ? ulf_pkg::TX_PAR : ulf_pkg::TX_STOP;
						end else begin
							tbit <= tbit + 4'h1;
							s.tx_line <= tsh[tbit + 4'h1];
						end
					end
					ulf_pkg::TX_PAR: if (tcnt == ulf_pkg::TICKS_BIT - 6'h01) begin
						tcnt <= 6'h00;
						s.tx_line <= 1'b1;
						tst <= ulf_pkg::TX_STOP;
					end
					ulf_pkg::TX_STOP: if (tcnt == stop_len - 6'h01) begin
						tst <= ulf_pkg::TX_IDLE;
					end
					default: tst <= ulf_pkg::TX_IDLE;
				endcase
			end
		end
	end

	// Receiver, samples mid-bit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst <= ulf_pkg::RX_IDLE;
			rcnt <= 4'h0;
			rbit <= 4'h0;
			rsh <= 9'h000;
			rpar <= 1'b0;
			rzero <= 1'b0;
			s.rx_push <= 1'b0;
			s.rx_data <= 8'h00;
			s.rx_perr <= 1'b0;
			s.rx_ferr <= 1'b0;
			s.rx_brk <= 1'b0;
		end else begin
			s.rx_push <= 1'b0;
			if (tick) begin
				rcnt <= rcnt + 4'h1;
				case (rst)
					ulf_pkg::RX_IDLE: begin
						rcnt <= 4'h0;
						if (!s.rx_line) rst <= ulf_pkg::RX_START;
					end
					ulf_pkg::RX_START: if (rcnt == ulf_pkg::TICKS_HALF) begin
						rcnt <= 4'h0;
						rbit <= 4'h0;
						rsh <= 9'h000;
						rzero <= 1'b1;
						rst <= s.rx_line ? ulf_pkg::RX_IDLE : ulf_pkg::RX_DATA;
					end
					ulf_pkg::RX_DATA: if (rcnt == 4'hf) begin
						rsh[rbit] <= s.rx_line;
						rzero <= rzero & !s.rx_line;
						if (rbit == nbits - 4'h1)
							rst <= s.par_en ? ulf_pkg::RX_PAR : ulf_pkg::RX_STOP;
						else
							rbit <= rbit + 4'h1;
					end
					ulf_pkg::RX_PAR: if (rcnt == 4'hf) begin
						rpar <= s.rx_line;
						rzero <= rzero & !s.rx_line;
						rst <= ulf_pkg::RX_STOP;
					end
					ulf_pkg::RX_STOP: if (rcnt == 4'hf) begin
						s.rx_push <= 1'b1;
						if (rzero && !s.rx_line) begin
							s.rx_data <= 8'h00;
							s.rx_brk <= 1'b1;
							s.rx_perr <= 1'b0;
							s.rx_ferr <= 1'b0;
							rst <= ulf_pkg::RX_BRKW;
						end else begin
							s.rx_data <= rsh[7:0] & mask;
							s.rx_brk <= 1'b0;
							s.rx_ferr <= !s.rx_line;
							s.rx_perr <= s.nine_bit ? rsh[8] : s.par_en &&
								(rpar != par_of(rsh[7:0] & mask, s.par_even, s.par_force));
							rst <= ulf_pkg::RX_IDLE;
						end
					end
					ulf_pkg::RX_BRKW: if (s.rx_line) rst <= ulf_pkg::RX_IDLE;
					default: rst <= ulf_pkg::RX_IDLE;
				endcase
			end
		end
	end
endmodule

// [hw/ulf_top.sv]
`timescale 1ns/1ns
// ****************************************************************
// Line format, line status and modem control with AXI4-Lite slave
// ****************************************************************
module ulf_top (
	input wire logic aclk, // System clock, 100 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [ulf_pkg::AXI_ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [ulf_pkg::AXI_ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic serial_rx_line, // Serial input
	output logic serial_tx_line, // Serial output
	input wire logic cts_n, // Clear to send, active low
	output logic dtr_n, // Terminal ready, active low
	output logic rts_n, // Request to send, active low
	output logic rx_status_irq // Receiver status interrupt
);
	ulf_ser_if ser ();

	logic aw_held, w_held, w_lane;
	logic [ulf_pkg::AXI_ADDR_W-1:0] aw_addr;
	logic [7:0] w_byte;
	logic [7:0] divisor_low_byte, divisor_high_byte;
	logic [7:0] line_format_control, modem_line_control;
	logic [7:0] additional_control_register;
	logic [3:0] interrupt_enable_register;
	logic fifo_mode;
	logic [7:0] rx_hold_data, tx_hold_data;
	logic rx_hold_full, rx_head_perr, rx_head_ferr, rx_head_brk;
	logic rx_overrun, rx_err_any, tx_hold_full;
	logic wr_en, rd_en, div_access, stat_visible, loop_on, afc_on, tx_wire;
	logic wr_data, rd_data, rd_stat, wr_fifo, flush_rx, flush_tx;
	logic [3:0] wr_idx, rd_idx;
	logic [7:0] rd_val, line_status_value;
	logic rx_errs;

	// Address decode of both channels
	assign wr_idx = aw_addr[5:2];
	assign rd_idx = s_axi_araddr[5:2];
	assign wr_en = aw_held && w_held && !s_axi_bvalid;
	assign rd_en = s_axi_arvalid && s_axi_arready;
	assign div_access = line_format_control[ulf_pkg::FMT_DIV_ACCESS];
	assign stat_visible = !div_access &&
		!additional_control_register[ulf_pkg::ADD_HIDE_STAT];
	assign wr_data = wr_en && w_lane && wr_idx == ulf_pkg::IDX_DATA && !div_access;
	assign rd_data = rd_en && rd_idx == ulf_pkg::IDX_DATA && !div_access;
	assign rd_stat = rd_en && rd_idx == ulf_pkg::IDX_LINE_STAT && stat_visible;
	assign wr_fifo = wr_en && w_lane && wr_idx == ulf_pkg::IDX_FIFO;
	assign flush_rx = wr_fifo && (w_byte[1] || w_byte[0] != fifo_mode);
	assign flush_tx = wr_fifo && w_byte[2];

	// Mode decode
	assign loop_on = modem_line_control[ulf_pkg::MDM_LOOP];
	assign afc_on = modem_line_control[ulf_pkg::MDM_AUTO_FLOW] && fifo_mode;
	assign tx_wire = ser.tx_line && !line_format_control[ulf_pkg::FMT_BREAK];
	assign rx_errs = rx_overrun || rx_head_perr || rx_head_ferr || rx_head_brk;

	// Format and flow fields to the engine
	assign ser.divisor = {divisor_high_byte, divisor_low_byte};
	assign ser.word_len = line_format_control[1:0];
	assign ser.two_stop = line_format_control[ulf_pkg::FMT_STOP];
	assign ser.nine_bit = additional_control_register[ulf_pkg::ADD_NINE];
	assign ser.par_en = line_format_control[ulf_pkg::FMT_PAR_EN] && !ser.nine_bit;
	assign ser.par_even = line_format_control[ulf_pkg::FMT_PAR_EVEN];
	assign ser.par_force = line_format_control[ulf_pkg::FMT_PAR_FORCE];
	assign ser.tx_ninth = additional_control_register[ulf_pkg::ADD_TX_NINTH];
	assign ser.cts_ok = !afc_on ||
		(loop_on ? modem_line_control[ulf_pkg::MDM_RTS] : !cts_n);
	assign ser.tx_valid = tx_hold_full;
	assign ser.tx_data = tx_hold_data;
	assign ser.rx_line = loop_on ? tx_wire : serial_rx_line;

	ulf_serial u_serial (
		.aclk(aclk),
		.aresetn(aresetn),
		.s(ser)
	);

	// Line status word
	always_comb begin
		line_status_value = {rx_err_any,
			!tx_hold_full && ser.tx_idle,
			!tx_hold_full,
			rx_head_brk,
			rx_head_ferr,
			rx_head_perr,
			rx_overrun,
			rx_hold_full};
	end

	// Read data selection
	always_comb begin
		rd_val = 8'h00;
		case (rd_idx)
			ulf_pkg::IDX_DATA: rd_val = div_access ? divisor_low_byte : rx_hold_data;
			ulf_pkg::IDX_IRQ_EN: rd_val = div_access ? divisor_high_byte :
				{4'h0, interrupt_enable_register};
			ulf_pkg::IDX_FIFO: begin
				if (interrupt_enable_register[2] && rx_errs)
					rd_val = {{2{fifo_mode}}, 6'h06};
				else if (interrupt_enable_register[0] && rx_hold_full)
					rd_val = {{2{fifo_mode}}, 6'h04};
				else if (interrupt_enable_register[1] && !tx_hold_full)
					rd_val = {{2{fifo_mode}}, 6'h02};
				else
					rd_val = {{2{fifo_mode}}, 6'h01};
			end
			ulf_pkg::IDX_LINE_FMT: rd_val = line_format_control;
			ulf_pkg::IDX_MODEM: rd_val = modem_line_control;
			ulf_pkg::IDX_LINE_STAT: rd_val = stat_visible ? line_status_value : 8'h00;
			ulf_pkg::IDX_ADD_CTL: rd_val = additional_control_register;
			default: rd_val = 8'h00;
		endcase
	end

	// Decoded index answers OKAY, anything else SLVERR
	function automatic logic [1:0] resp_of(input logic [3:0] idx);
		resp_of = (idx <= ulf_pkg::IDX_LINE_STAT || idx == ulf_pkg::IDX_ADD_CTL) ?
			ulf_pkg::RESP_OKAY : ulf_pkg::RESP_SLVERR;
	endfunction

	// ****************************************************************
	// AXI4-Lite write channel
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ulf_pkg::RESP_OKAY;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_byte <= 8'h00;
			w_lane <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				s_axi_awready <= 1'b0;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				s_axi_wready <= 1'b0;
				w_byte <= s_axi_wdata[7:0];
				w_lane <= s_axi_wstrb[0];
			end
			if (wr_en) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= resp_of(wr_idx);
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// AXI4-Lite read channel
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= ulf_pkg::RESP_OKAY;
		end else begin
			if (rd_en) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h00_0000, rd_val};
				s_axi_rresp <= resp_of(rd_idx);
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			divisor_low_byte <= ulf_pkg::DIV_RST[7:0];
			divisor_high_byte <= ulf_pkg::DIV_RST[15:8];
			line_format_control <= ulf_pkg::CTL_RST;
			modem_line_control <= ulf_pkg::CTL_RST;
			additional_control_register <= ulf_pkg::CTL_RST;
			interrupt_enable_register <= 4'h0;
			fifo_mode <= 1'b0;
		end else if (wr_en && w_lane) begin
			case (wr_idx)
				ulf_pkg::IDX_DATA: if (div_access) divisor_low_byte <= w_byte;
				ulf_pkg::IDX_IRQ_EN: begin
					if (div_access)
						divisor_high_byte <= w_byte;
					else
						interrupt_enable_register <= w_byte[3:0];
				end
				ulf_pkg::IDX_FIFO: fifo_mode <= w_byte[0];
				ulf_pkg::IDX_LINE_FMT: line_format_control <= w_byte;
				ulf_pkg::IDX_MODEM: modem_line_control <= w_byte;
				ulf_pkg::IDX_ADD_CTL: additional_control_register <= w_byte;
				default: fifo_mode <= fifo_mode;
			endcase
		end
	end

	// Transmit holding buffer, a new write wins over the engine taking it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_hold_full <= 1'b0;
			tx_hold_data <= 8'h00;
		end else if (wr_data) begin
			tx_hold_full <= 1'b1;
			tx_hold_data <= w_byte;
		end else if (ser.tx_take || flush_tx) begin
			tx_hold_full <= 1'b0;
		end
	end

	// Receive holding buffer, a push keeps the old character when full
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_hold_full <= 1'b0;
			rx_hold_data <= 8'h00;
		end else if (ser.rx_push && (!rx_hold_full || rd_data)) begin
			rx_hold_full <= 1'b1;
			rx_hold_data <= ser.rx_data;
		end else if (rd_data || flush_rx) begin
			rx_hold_full <= 1'b0;
		end
	end

	// Head flags load with the character and clear on a status read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_head_perr <= 1'b0;
			rx_head_ferr <= 1'b0;
			rx_head_brk <= 1'b0;
		end else if (ser.rx_push && (!rx_hold_full || rd_data)) begin
			rx_head_perr <= ser.rx_perr;
			rx_head_ferr <= ser.rx_ferr;
			rx_head_brk <= ser.rx_brk;
		end else if (rd_stat) begin
			rx_head_perr <= 1'b0;
			rx_head_ferr <= 1'b0;
			rx_head_brk <= 1'b0;
		end
	end

	// Sticky overrun and error summary, a new event beats the read clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_overrun <= 1'b0;
			rx_err_any <= 1'b0;
		end else begin
			if (ser.rx_push && rx_hold_full && !rd_data)
				rx_overrun <= 1'b1;
			else if (rd_stat)
				rx_overrun <= 1'b0;
			if (ser.rx_push && (!rx_hold_full || rd_data) &&
				(ser.rx_perr || ser.rx_ferr || ser.rx_brk))
				rx_err_any <= 1'b1;
			else if (rd_stat || flush_rx)
				rx_err_any <= 1'b0;
		end
	end

	// ****************************************************************
	// Pins and interrupt, all registered
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_tx_line <= 1'b1;
			dtr_n <= 1'b1;
			rts_n <= 1'b1;
			rx_status_irq <= 1'b0;
		end else begin
			serial_tx_line <= loop_on || tx_wire;
			dtr_n <= loop_on || !modem_line_control[ulf_pkg::MDM_DTR];
			rts_n <= loop_on || !modem_line_control[ulf_pkg::MDM_RTS] ||
				(afc_on && rx_hold_full);
			rx_status_irq <= interrupt_enable_register[ulf_pkg::IRQ_RX_STAT] &&
				rx_errs;
		end
	end
endmodule

// [sim/ulf_props.sv]
`timescale 1ns/1ns
// ****
// Port checker for the line format block
// ****
module ulf_props (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset
	input wire logic [ulf_pkg::AXI_ADDR_W-1:0] s_axi_awaddr, // AW addr
	input wire logic s_axi_awvalid, // AW valid
	input wire logic s_axi_awready, // AW ready
	input wire logic [31:0] s_axi_wdata, // W data
	input wire logic [3:0] s_axi_wstrb, // W strobe
	input wire logic s_axi_wvalid, // W valid
	input wire logic s_axi_bvalid, // B valid
	input wire logic s_axi_bready, // B ready
	input wire logic [31:0] s_axi_rdata, // R data
	input wire logic s_axi_rvalid, // R valid
	input wire logic s_axi_rready, // R ready
	input wire logic serial_tx_line, // Serial out
	input wire logic dtr_n, // Terminal ready
	input wire logic rts_n // Request
);
	logic [7:0] sm;
	logic [7:0] sf;
	logic bhs;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Write response handshake
	assign bhs = s_axi_bvalid && s_axi_bready;
	// Shadow copies of modem and format registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sm <= 8'h00;
			sf <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wstrb[0]) begin
			if (s_axi_awaddr[5:2] == ulf_pkg::IDX_MODEM) sm <= s_axi_wdata[7:0];
			if (s_axi_awaddr[5:2] == ulf_pkg::IDX_LINE_FMT) sf <= s_axi_wdata[7:0];
		end
	end
	b_done_a: assert property (bhs |=> !s_axi_bvalid)
		else $error("write response repeated");
	r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response repeated");
	aw_busy_a: assert property ($rose(s_axi_bvalid) |-> !s_axi_awready)
		else $error("write address taken while busy");
	r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	rst_out_a: assert property ($rose(aresetn) |-> serial_tx_line && dtr_n && rts_n)
		else $error("outputs not idle after reset");
	dtr_drive_a: assert property (bhs |=> dtr_n == (sm[4] || !sm[0]))
		else $error("terminal ready level wrong");
	rts_drive_a: assert property (bhs && !sm[5] |=> rts_n == (sm[4] || !sm[1]))
		else $error("request level wrong");
	loop_idle_a: assert property (bhs && sm[4] |=> serial_tx_line)
		else $error("serial out not idle in loopback");
	break_low_a: assert property (bhs && sf[6] && !sm[4] |=> !serial_tx_line)
		else $error("serial out not low in break");
endmodule
bind ulf_top ulf_props u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_bvalid,
	.s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .serial_tx_line,
	.dtr_n, .rts_n);

// [sim/ulf_serial_peer.sv]
`timescale 1ns/1ns
// ****
// Remote serial device
// ****
module ulf_serial_peer (
	input wire logic aclk, // Clock
	input wire logic tx_line, // From block
	output logic rx_line // To block
);
	logic [11:0] cap;
	logic got = 1'b0;
	// Line idles high between frames
	initial rx_line = 1'b1;
	// Send n bits lsb first, 16 clocks a bit, then one idle bit
	task automatic send(input logic [11:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			rx_line <= b[i];
			repeat (16) @(posedge aclk);
		end
		rx_line <= 1'b1;
		repeat (16) @(posedge aclk);
	endtask
	// Sample twelve bit slots at mid-bit after a start edge
	always @(negedge tx_line) begin
		got = 1'b0;
		repeat (8) @(posedge aclk);
		for (int i = 0; i < 12; i++) begin
			cap[i] = tx_line;
			repeat (16) @(posedge aclk);
		end
		got = 1'b1;
	end
endmodule

// [sim/ulf_top_tb.sv]
`timescale 1ns/1ns
// ****
// Bench for the line format block
// ****
module ulf_top_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [5:0] s_axi_awaddr = 6'h00;
	logic [5:0] s_axi_araddr = 6'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, cts_n = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic [31:0] s_axi_rdata, rv;
	logic serial_rx_line, serial_tx_line, dtr_n, rts_n, rx_status_irq;
	int err_total = 0;
	int total_checks = 0;
	// Clock
	always #5 aclk = ~aclk;
	ulf_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_rx_line,
		.serial_tx_line, .cts_n, .dtr_n, .rts_n, .rx_status_irq);
	ulf_serial_peer peer (.aclk, .tx_line(serial_tx_line), .rx_line(serial_rx_line));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic tmo(input int n);
		if (n >= 400) begin
			err_total++;
			$display("FAIL %0t wait expired", $time);
			wrap_up();
		end
	endtask
	// AXI write, each channel released when taken
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 400);
		tmo(n);
	endtask
	// AXI read and compare of the whole word, upper bytes expected zero
	task automatic rc(input logic [5:0] a, input logic [7:0] e);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 400);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		tmo(n);
		chk(rv, {24'h000000, e});
	endtask
	task automatic wait_got;
		int n;
		n = 0;
		while (peer.got !== 1'b1 && n < 400) begin
			@(posedge aclk);
			n++;
		end
		tmo(n);
	endtask
	// Expected line samples: start, data, parity, then high
	function automatic logic [11:0] frame(input logic [7:0] c, input logic [7:0] d);
		logic [11:0] f;
		logic p;
		int n;
		n = 5 + int'(c[1:0]);
		f = 12'hffe;
		p = 1'b0;
		for (int i = 0; i < n; i++) begin
			f[i+1] = d[i];
			p ^= d[i];
		end
		if (c[3]) f[n+1] = c[5] ? !c[4] : (c[4] ? p : !p);
		return f;
	endfunction
	task automatic t_regs;
		rc(6'h14, 8'h60);
		chk(32'({dtr_n, rts_n, serial_tx_line}), 32'h7);
		wr(6'h0c, 8'h83);
		wr(6'h00, 8'h02);
		rc(6'h00, 8'h02);
		rc(6'h14, 8'h00);
		wr(6'h00, 8'h01);
		wr(6'h0c, 8'h03);
		wr(6'h20, 8'h40);
		rc(6'h14, 8'h00);
		wr(6'h20, 8'h00);
		rc(6'h18, 8'h00);
		chk(32'(rr), 32'(ulf_pkg::RESP_SLVERR));
		$display("registers done");
	endtask
	task automatic t_tx;
		logic [39:0] tab;
		tab = 40'h3b2b1a0900;
		for (int i = 0; i < 5; i++) begin
			wr(6'h0c, tab[8*i +: 8]);
			peer.got <= 1'b0;
			wr(6'h00, 8'ha5);
			rc(6'h14, 8'h00);
			rc(6'h14, 8'h20);
			wait_got();
			chk(32'(peer.cap), 32'(frame(tab[8*i +: 8], 8'ha5)));
		end
		rc(6'h14, 8'h60);
		$display("transmit formats done");
	endtask
	task automatic t_modem;
		wr(6'h10, 8'h03);
		@(posedge aclk);
		chk(32'({dtr_n, rts_n}), 32'h0);
		wr(6'h10, 8'h13);
		peer.got <= 1'b0;
		wr(6'h00, 8'h5a);
		repeat (200) @(posedge aclk);
		rc(6'h14, 8'h61);
		rc(6'h00, 8'h5a);
		chk(32'({peer.got, dtr_n, rts_n, serial_tx_line}), 32'h7);
		wr(6'h10, 8'h00);
		wr(6'h0c, 8'h43);
		@(posedge aclk);
		chk(32'(serial_tx_line), 32'h0);
		repeat (200) @(posedge aclk);
		wr(6'h0c, 8'h03);
		@(posedge aclk);
		chk(32'(serial_tx_line), 32'h1);
		$display("modem and break done");
	endtask
	task automatic t_rx;
		logic [31:0] lc, ls, dd;
		logic [47:0] fr;
		logic [15:0] nn;
		lc = 32'h0303031b;
		fr = 48'h0002220aa402;
		nn = 16'hcaab;
		ls = 32'hf163e9e5;
		dd = 32'h00115501;
		wr(6'h08, 8'h01);
		wr(6'h10, 8'h23);
		for (int i = 0; i < 4; i++) begin
			wr(6'h0c, lc[8*i +: 8]);
			wr(6'h04, {5'h00, i[0], 2'b00});
			repeat ((i == 2) ? 2 : 1) peer.send(fr[12*i +: 12], int'(nn[4*i +: 4]));
			chk(32'(rts_n), 32'h1);
			chk(32'(rx_status_irq), 32'(i[0]));
			rc(6'h14, ls[8*i +: 8]);
			rc(6'h14, 8'h61);
			chk(32'(rx_status_irq), 32'h0);
			rc(6'h00, dd[8*i +: 8]);
		end
		$display("receive errors done");
	endtask
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_tx();
		t_modem();
		t_rx();
		wrap_up();
	end
endmodule
